// ===== src/simb_mask_bank.sv
// general and modem event mask registers with masked interrupt summaries
`timescale 1ns/1ps
`include "simb_params.svh"
module simb_mask_bank (
  input wire logic core_clk,
  input wire logic nrst,
  input simb_pkg::simb_req_type reg_req,
  output simb_pkg::simb_rsp_type reg_rsp_ff,
  input wire logic [15:0] general_event_flags,
  input wire logic [15:0] modem_event_flags,
  output simb_pkg::simb_summary_type summary_ff,
  output logic [15:0] general_event_mask_ff,
  output logic [15:0] modem_event_mask_ff
);
  logic rst_meta_ff;
  logic rst_n_ff;
  logic [15:0] nxt_general_mask;
  logic [15:0] nxt_modem_mask;

  // reset release through two flops; async assert
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // merge a write into a mask, reserved bits forced high
  function automatic logic [15:0] merge_mask(input logic [15:0] wdata,
                                             input logic [15:0] rw_bits);
    merge_mask = (wdata & rw_bits) | (`SIMB_RESERVED_VALUE & ~rw_bits);
  endfunction

  // offset decode shared by write and read paths so the two cannot drift
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction

  // writable positions built from the field list, not the flat map;
  // the bench expects from the flat map, so a slip in either shows up
  localparam logic [15:0] gen_field_bits =
    (16'h0001 << `SIMB_SELFTEST_COMPLETE_BIT) |
    (16'h0001 << `SIMB_SELFTEST_FAILED_BIT) |
    (16'h0001 << `SIMB_SLEW_IDLE_BIT) |
    (16'h0001 << `SIMB_CONV_DONE_BIT) |
    (16'h0001 << `SIMB_BREAK_FRAME_BIT) |
    (16'h0001 << `SIMB_BREAK_PARITY_BIT) |
    (16'h0001 << `SIMB_SERIAL_FRAME_BIT) |
    (16'h0001 << `SIMB_SERIAL_PARITY_BIT);

  // modem fields, every position below the reserved top three
  localparam logic [15:0] modem_field_bits =
    (16'h0001 << `SIMB_GAP_ERR_BIT) |
    (16'h0001 << `SIMB_FRAME_ERR_BIT) |
    (16'h0001 << `SIMB_PARITY_ERR_BIT) |
    (16'h0001 << `SIMB_RX_THRESHOLD_BIT) |
    (16'h0001 << `SIMB_RX_FULL_BIT) |
    (16'h0001 << `SIMB_RX_EMPTY_BIT) |
    (16'h0001 << `SIMB_TX_THRESHOLD_BIT) |
    (16'h0001 << `SIMB_TX_FULL_BIT) |
    (16'h0001 << `SIMB_TX_EMPTY_BIT) |
    (16'h0001 << `SIMB_CARRIER_LOST_BIT) |
    (16'h0001 << `SIMB_CARRIER_FOUND_BIT) |
    (16'h0001 << `SIMB_SEND_PERMIT_DROP_BIT) |
    (16'h0001 << `SIMB_SEND_PERMIT_GAIN_BIT);

  // next mask values
  always_comb begin
    nxt_general_mask = general_event_mask_ff;
    nxt_modem_mask = modem_event_mask_ff;
    if (reg_req.wr_en && addr_hit(reg_req.addr, `SIMB_GEN_MASK_ADDR)) begin
      nxt_general_mask = merge_mask(reg_req.wdata, gen_field_bits);
    end
    if (reg_req.wr_en && addr_hit(reg_req.addr, `SIMB_MODEM_MASK_ADDR)) begin
      nxt_modem_mask = merge_mask(reg_req.wdata, modem_field_bits);
    end
  end

  // mask storage, all ones after reset so nothing fires early
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      general_event_mask_ff <= `SIMB_MASK_RESET;
      modem_event_mask_ff <= `SIMB_MASK_RESET;
    end else begin
      general_event_mask_ff <= nxt_general_mask;
      modem_event_mask_ff <= nxt_modem_mask;
    end
  end

  // read port, answer one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      reg_rsp_ff <= '0;
    end else begin
      // reads see the mask before a same-cycle write lands
      reg_rsp_ff.valid <= reg_req.rd_en;
      if (!reg_req.rd_en) begin
        reg_rsp_ff.rdata <= `SIMB_READ_UNMAPPED;
      end else if (addr_hit(reg_req.addr, `SIMB_GEN_MASK_ADDR)) begin
        reg_rsp_ff.rdata <= general_event_mask_ff;
      end else if (addr_hit(reg_req.addr, `SIMB_MODEM_MASK_ADDR)) begin
        reg_rsp_ff.rdata <= modem_event_mask_ff;
      end else begin
        reg_rsp_ff.rdata <= `SIMB_READ_UNMAPPED;
      end
    end
  end

  // summaries use the live status; reserved mask bits stay one so
  // unused status inputs can never leak through
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      summary_ff <= '0;
    end else begin
      summary_ff.general <= |(general_event_flags & ~general_event_mask_ff);
      summary_ff.modem <= |(modem_event_flags & ~modem_event_mask_ff);
    end
  end

  a_gen_summary: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    1'b1 |=> summary_ff.general ==
      $past(|(general_event_flags & ~general_event_mask_ff)))
    else $error("general summary mismatch");
  a_modem_summary: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    1'b1 |=> summary_ff.modem == $past(|(modem_event_flags & ~modem_event_mask_ff)))
    else $error("modem summary mismatch");
  // gating of the summaries
  a_masked_quiet: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (general_event_mask_ff == `SIMB_MASK_RESET &&
     modem_event_mask_ff == `SIMB_MASK_RESET) |=>
      (!summary_ff.general && !summary_ff.modem))
    else $error("summary raised while fully masked");
  a_unmask_fires: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (general_event_flags[`SIMB_SELFTEST_COMPLETE_BIT] &&
     !general_event_mask_ff[`SIMB_SELFTEST_COMPLETE_BIT]) |=> summary_ff.general)
    else $error("unmasked event did not raise summary");

  // reserved positions hold one whatever was written
  a_gen_reserved: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (general_event_mask_ff | `SIMB_GEN_RW_BITS) == `SIMB_RESERVED_VALUE)
    else $error("general reserved bits not one");
  a_modem_reserved: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (modem_event_mask_ff | `SIMB_MODEM_RW_BITS) == `SIMB_RESERVED_VALUE)
    else $error("modem reserved bits not one");

  // register access: writes land next cycle, reads answer next cycle
  a_gen_write: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (reg_req.wr_en && reg_req.addr == `SIMB_GEN_MASK_ADDR) |=>
      (general_event_mask_ff & `SIMB_GEN_RW_BITS) == ($past(reg_req.wdata) & `SIMB_GEN_RW_BITS))
    else $error("general mask write lost");
  a_modem_write: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (reg_req.wr_en && reg_req.addr == `SIMB_MODEM_MASK_ADDR) |=>
      (modem_event_mask_ff & `SIMB_MODEM_RW_BITS) == ($past(reg_req.wdata) & `SIMB_MODEM_RW_BITS))
    else $error("modem mask write lost");
  a_read_back: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (reg_req.rd_en && !reg_req.wr_en && reg_req.addr == `SIMB_GEN_MASK_ADDR) |=>
      reg_rsp_ff.valid && reg_rsp_ff.rdata == general_event_mask_ff)
    else $error("general mask read mismatch");
  a_modem_read_back: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (reg_req.rd_en && !reg_req.wr_en && reg_req.addr == `SIMB_MODEM_MASK_ADDR) |=>
      reg_rsp_ff.valid && reg_rsp_ff.rdata == modem_event_mask_ff)
    else $error("modem mask read mismatch");
  a_read_keeps_old: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (reg_req.rd_en && reg_req.wr_en && reg_req.addr == `SIMB_GEN_MASK_ADDR) |=>
      reg_rsp_ff.rdata == $past(general_event_mask_ff))
    else $error("read during write not old value");

  // idle bus clears the response to the unmapped value; stray writes leave both masks alone
  a_rsp_idle: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    !reg_req.rd_en |=> !reg_rsp_ff.valid && reg_rsp_ff.rdata == `SIMB_READ_UNMAPPED)
    else $error("response without a read");
  a_stray_write: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (reg_req.wr_en && reg_req.addr != `SIMB_GEN_MASK_ADDR &&
     reg_req.addr != `SIMB_MODEM_MASK_ADDR) |=>
      $stable(general_event_mask_ff) && $stable(modem_event_mask_ff))
    else $error("write to other offset changed a mask");

  // first cycle out of reset: all masked, nothing raised
  a_reset_value: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    $rose(rst_n_ff) |-> general_event_mask_ff == `SIMB_MASK_RESET &&
      modem_event_mask_ff == `SIMB_MASK_RESET && !summary_ff.general &&
      !summary_ff.modem && !reg_rsp_ff.valid)
    else $error("state after reset not masked");

  // one raised flag alone: the summary follows exactly its own mask bit
  for (genvar g = 0; g < $bits(general_event_mask_ff); g++) begin : g_bit_gate
    a_gen_bit_gate: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
      (general_event_flags == (16'h0001 << g)) |=>
        summary_ff.general == !$past(general_event_mask_ff[g]))
      else $error("general bit gate wrong");
    a_modem_bit_gate: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
      (modem_event_flags == (16'h0001 << g)) |=>
        summary_ff.modem == !$past(modem_event_mask_ff[g]))
      else $error("modem bit gate wrong");
  end

  // main scenarios worth seeing at least once
  c_general_summary_flag: cover property (@(posedge core_clk) disable iff (!rst_n_ff)
    $rose(summary_ff.general));
  c_modem_irq: cover property (@(posedge core_clk) disable iff (!rst_n_ff)
    $rose(summary_ff.modem));
  c_modem_write: cover property (@(posedge core_clk) disable iff (!rst_n_ff)
    reg_req.wr_en && reg_req.addr == `SIMB_MODEM_MASK_ADDR);
  c_read_during_write: cover property (@(posedge core_clk) disable iff (!rst_n_ff)
    reg_req.rd_en && reg_req.wr_en);
  c_reset_release: cover property (@(posedge core_clk) disable iff (!rst_n_ff)
    $rose(rst_n_ff));
endmodule

// ===== common/simb_params.svh
// register offsets, reset values and field positions of the event mask bank
`ifndef SIMB_PARAMS_SVH
`define SIMB_PARAMS_SVH
`define SIMB_GEN_MASK_ADDR 8'h1e
`define SIMB_MODEM_MASK_ADDR 8'h1f
`define SIMB_MASK_RESET 16'hffff
// writable bits; everything else is reserved and reads one
`define SIMB_GEN_RW_BITS 16'h06cf
`define SIMB_MODEM_RW_BITS 16'h1fff
`define SIMB_RESERVED_VALUE 16'hffff
`define SIMB_READ_UNMAPPED 16'h0000
// general mask fields
`define SIMB_SELFTEST_COMPLETE_BIT 10
`define SIMB_SELFTEST_FAILED_BIT 9
`define SIMB_SLEW_IDLE_BIT 7
`define SIMB_CONV_DONE_BIT 6
`define SIMB_BREAK_FRAME_BIT 3
`define SIMB_BREAK_PARITY_BIT 2
`define SIMB_SERIAL_FRAME_BIT 1
`define SIMB_SERIAL_PARITY_BIT 0
// modem mask fields
`define SIMB_GAP_ERR_BIT 12
`define SIMB_FRAME_ERR_BIT 11
`define SIMB_PARITY_ERR_BIT 10
`define SIMB_RX_THRESHOLD_BIT 9
`define SIMB_RX_FULL_BIT 8
`define SIMB_RX_EMPTY_BIT 7
`define SIMB_TX_THRESHOLD_BIT 6
`define SIMB_TX_FULL_BIT 5
`define SIMB_TX_EMPTY_BIT 4
`define SIMB_CARRIER_LOST_BIT 3
`define SIMB_CARRIER_FOUND_BIT 2
`define SIMB_SEND_PERMIT_DROP_BIT 1
`define SIMB_SEND_PERMIT_GAIN_BIT 0
`endif

// ===== common/simb_pkg.sv
// types shared by the event mask bank
package simb_pkg;
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [15:0] wdata;
  } simb_req_type;
  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } simb_rsp_type;
  typedef struct packed {
    logic general;
    logic modem;
  } simb_summary_type;
endpackage

// ===== dv/simb_mask_bank_tb.sv
// self-checking bench for the event mask bank: reset, random access, per-bit gating
`timescale 1ns/1ps
`include "simb_params.svh"
module simb_mask_bank_tb;
  logic core_clk;
  logic nrst;
  simb_pkg::simb_req_type reg_req;
  simb_pkg::simb_rsp_type reg_rsp_ff;
  logic [15:0] general_event_flags;
  logic [15:0] modem_event_flags;
  simb_pkg::simb_summary_type summary_ff;
  logic [15:0] general_event_mask_ff;
  logic [15:0] modem_event_mask_ff;
  int n_errors;
  int n_compared;
  logic [15:0] rd_data;
  logic [15:0] eg;
  logic [15:0] em;
  logic [31:0] r;
  simb_mask_bank simb_mask_bank_i (.core_clk(core_clk), .nrst(nrst), .reg_req(reg_req),
    .reg_rsp_ff(reg_rsp_ff), .general_event_flags(general_event_flags),
    .modem_event_flags(modem_event_flags), .summary_ff(summary_ff),
    .general_event_mask_ff(general_event_mask_ff), .modem_event_mask_ff(modem_event_mask_ff));
  // free-running core clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // reserved bits stay one whatever is written
  function automatic logic [15:0] exp_mask(input logic [15:0] d, input logic [15:0] rw);
    return (d & rw) | ~rw;
  endfunction
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  // one request per cycle, struct assigned whole so no signal changes twice per step
  task automatic req(input logic w, input logic rd, input logic [7:0] a, input logic [15:0] d);
    reg_req = '{wr_en: w, rd_en: rd, addr: a, wdata: d};
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    req(1'b0, 1'b1, a, 16'h0000);
    chk1(reg_rsp_ff.valid, 1'b1, "read valid");
    chk16(reg_rsp_ff.rdata, exp, "read data");
  endtask
  // summaries lag flags and masks by one cycle
  task automatic sum_chk(input logic [15:0] gf, input logic [15:0] mf);
    general_event_flags = gf;
    modem_event_flags = mf;
    @(posedge core_clk);
    @(negedge core_clk);
    chk1(summary_ff.general, |(gf & ~eg), "general summary");
    chk1(summary_ff.modem, |(mf & ~em), "modem summary");
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    n_errors = 0;
    n_compared = 0;
    nrst = 1'b0;
    reg_req = '0;
    general_event_flags = 16'h0000;
    modem_event_flags = 16'h0000;
    r = $urandom(32'h4bd0);
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    eg = `SIMB_MASK_RESET;
    em = `SIMB_MASK_RESET;
    // everything masked out of reset, even with all flags raised
    rd_chk(`SIMB_GEN_MASK_ADDR, 16'hffff);
    rd_chk(`SIMB_MODEM_MASK_ADDR, 16'hffff);
    sum_chk(16'hffff, 16'hffff);
    $display("test reset_values done");
    // random masks and flags, stray write and read at an unmapped offset
    for (int i = 0; i < 12; i++) begin
      eg = exp_mask(16'($urandom), `SIMB_GEN_RW_BITS);
      em = exp_mask(16'($urandom), `SIMB_MODEM_RW_BITS);
      req(1'b1, 1'b0, `SIMB_GEN_MASK_ADDR, (i == 0) ? 16'h0000 : {eg[15:1], eg[0]});
      if (i == 0) eg = exp_mask(16'h0000, `SIMB_GEN_RW_BITS);
      req(1'b1, 1'b0, `SIMB_MODEM_MASK_ADDR, em);
      req(1'b1, 1'b0, 8'h20, 16'($urandom));
      chk16(general_event_mask_ff, eg, "general mask port");
      rd_chk(`SIMB_GEN_MASK_ADDR, eg);
      rd_chk(`SIMB_MODEM_MASK_ADDR, em);
      rd_chk(8'h20, `SIMB_READ_UNMAPPED);
      sum_chk(16'($urandom), 16'($urandom));
    end
    $display("test random_access done");
    // walk each writable bit: only its own flag may pass when it alone is open
    for (int b = 0; b < 16; b++) begin
      eg = `SIMB_GEN_RW_BITS & (16'h0001 << b) ? ~(16'h0001 << b) : 16'hffff;
      em = `SIMB_MODEM_RW_BITS & (16'h0001 << b) ? ~(16'h0001 << b) : 16'hffff;
      req(1'b1, 1'b0, `SIMB_GEN_MASK_ADDR, ~(16'h0001 << b));
      req(1'b1, 1'b0, `SIMB_MODEM_MASK_ADDR, ~(16'h0001 << b));
      chk16(modem_event_mask_ff, em, "modem mask port");
      sum_chk(16'h0001 << b, 16'h0001 << b);
      sum_chk(~(16'h0001 << b), ~(16'h0001 << b));
    end
    $display("test bit_walk done");
    // read and write in one cycle returns the old word; then open every mask
    req(1'b1, 1'b1, `SIMB_GEN_MASK_ADDR, 16'h0000);
    chk16(reg_rsp_ff.rdata, eg, "read during write");
    eg = exp_mask(16'h0000, `SIMB_GEN_RW_BITS);
    em = exp_mask(16'h0000, `SIMB_MODEM_RW_BITS);
    req(1'b1, 1'b0, `SIMB_MODEM_MASK_ADDR, 16'h0000);
    chk16(general_event_mask_ff, eg, "general mask opened");
    sum_chk(16'hffff, 16'hffff);
    // reset in mid-run must mask everything again at once, bus idle
    reg_req = '0;
    nrst = 1'b0;
    @(negedge core_clk);
    chk16(general_event_mask_ff, `SIMB_MASK_RESET, "general mask in reset");
    chk16(modem_event_mask_ff, `SIMB_MASK_RESET, "modem mask in reset");
    chk1(summary_ff.general | summary_ff.modem, 1'b0, "summary in reset");
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    eg = `SIMB_MASK_RESET;
    em = `SIMB_MASK_RESET;
    rd_chk(`SIMB_GEN_MASK_ADDR, `SIMB_MASK_RESET);
    rd_chk(`SIMB_MODEM_MASK_ADDR, `SIMB_MASK_RESET);
    sum_chk(16'hffff, 16'hffff);
    $display("test mid_reset done");
    give_verdict();
  end
endmodule
